//--- logic/sfe_erase_ctrl.sv
`timescale 1ns/1ps
module sfe_erase_ctrl
  import sfe_pkg::*;
#(
  parameter int SECT_ERASE_CYC = 20000,
  parameter int BLK32_ERASE_CYC = 50000,
  parameter int BLK64_ERASE_CYC = 80000,
  parameter int CHIP_ERASE_CYC = 400000,
  parameter int PROG_CYC = 5000,
  parameter int STAT_WR_CYC = 5000,
  parameter int CNT_W = 24
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // serial pins
  input wire logic csN,
  input wire logic sck,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  // page program datapath
  input wire logic progStart,
  output logic progDone,
  // array erase request, valid for one cycle
  output sfe_erase_req_t eraseDone,
  // visible state
  output logic [7:0] statusReg,
  output logic [7:0] funcReg,
  output logic [7:0] readParam,
  output logic [7:0] extReadParam,
  output logic quadMode
);

  // ======================================================
  // parameter checks
  if (CNT_W < 2 || CNT_W > 31 || CHIP_ERASE_CYC >= 2 ** CNT_W || SECT_ERASE_CYC < 1 ||
      BLK32_ERASE_CYC < 1 || BLK64_ERASE_CYC < 1 || CHIP_ERASE_CYC < 1 ||
      PROG_CYC < 1 || PROG_CYC >= 2 ** CNT_W || STAT_WR_CYC < 1 || STAT_WR_CYC >= 2 ** CNT_W)
  begin : gBadParam
    $error("sfe_erase_ctrl: counts do not fit CNT_W");
  end

  // ======================================================
  // pin synchronisers and edge detect
  logic [1:0] csSync;
  logic [1:0] sckSync;
  logic [3:0] ioSync1;
  logic [3:0] ioSync2;
  logic csPrev;
  logic sckPrev;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      csSync <= 2'h3;
      sckSync <= 2'h0;
      ioSync1 <= 4'h0;
      ioSync2 <= 4'h0;
      csPrev <= 1'b1;
      sckPrev <= 1'b0;
    end
    else
    begin
      csSync <= {csSync[0], csN};
      sckSync <= {sckSync[0], sck};
      ioSync1 <= ioIn;
      ioSync2 <= ioSync1;
      csPrev <= csSync[1];
      sckPrev <= sckSync[1];
    end
  end

  wire csLow = ~csSync[1];
  wire csRise = csSync[1] & ~csPrev;
  wire sckRise = csLow & sckSync[1] & ~sckPrev;
  wire sckFall = csLow & ~sckSync[1] & sckPrev;

  // ======================================================
  // command shifter, one bit or one nibble per rising clock
  logic [31:0] shiftReg;
  logic [5:0] bitCnt;
  logic [7:0] opcode;
  logic rdStat;
  logic rdFunc;

  wire [31:0] shiftIn = quadMode ? {shiftReg[27:0], ioSync2} : {shiftReg[30:0], ioSync2[0]};
  wire [5:0] cntStep = quadMode ? 6'h04 : 6'h01;
  wire [5:0] cntIn = (bitCnt >= LEN_SAT) ? bitCnt : bitCnt + cntStep;
  wire opDone = sckRise && cntIn == LEN_OP;

  // ======================================================
  // operation state
  sfe_op_state_t eraseSt;
  sfe_op_state_t progSt;
  sfe_op_state_t next_eraseSt;
  sfe_op_state_t next_progSt;
  sfe_erase_kind_t eraseKind;
  logic [23:0] eraseBase;
  logic [CNT_W-1:0] eraseCnt;
  logic [CNT_W-1:0] progCnt;
  logic [CNT_W-1:0] statCnt;
  logic [TMR_W-1:0] susTmr;
  logic [TMR_W-1:0] guardTmr;
  logic writeEnableLatch;
  logic [7:0] statNv;
  logic [7:0] funcOtp;

  wire program_suspended_flag = progSt == OS_SUSP;
  wire erase_suspended_flag = eraseSt == OS_SUSP;
  wire anySusp = program_suspended_flag | erase_suspended_flag;
  wire eraseRun = eraseSt == OS_RUN;
  wire progRun = progSt == OS_RUN;
  wire in_progress_flag = eraseRun | progRun | (statCnt != '0) | (susTmr != '0);

  // ======================================================
  // command decode at select rise
  wire isSect = opcode == OP_SECT_A || opcode == OP_SECT_B;
  wire isBlk32 = opcode == OP_BLK32;
  wire isBlk64 = opcode == OP_BLK64;
  wire isChip = opcode == OP_CHIP_A || opcode == OP_CHIP_B;
  wire isSusp = opcode == OP_SUSP_A || opcode == OP_SUSP_B;
  wire isResm = opcode == OP_RESM_A || opcode == OP_RESM_B;
  wire lenOp = bitCnt == LEN_OP;
  wire lenData = bitCnt == LEN_DATA;
  wire lenAddr = bitCnt == LEN_ADDR;
  wire idleOk = csRise && !in_progress_flag;
  wire wrOk = idleOk && writeEnableLatch && !anySusp;
  wire regionCmd = (isSect || isBlk32 || isBlk64) && lenAddr;
  wire goErase = wrOk && (regionCmd || (isChip && lenOp));
  wire goSetWel = idleOk && !program_suspended_flag && opcode == OP_SET_WEL && lenOp;
  wire goClrWel = idleOk && !anySusp && opcode == OP_CLR_WEL && lenOp;
  wire goStatWr = wrOk && opcode == OP_STAT_WR && lenData;
  wire goFuncWr = wrOk && opcode == OP_FUNC_WR && lenData;
  wire goQuadOn = idleOk && !anySusp && !quadMode && opcode == OP_QUAD_ON && lenOp;
  wire goQuadOff = idleOk && !anySusp && quadMode && opcode == OP_QUAD_OFF && lenOp;
  wire goRdPar = idleOk && (opcode == OP_RDPAR_A || opcode == OP_RDPAR_B) && lenData;
  wire goXRdPar = idleOk && opcode == OP_XRDPAR && lenData;
  wire suspTarget = progRun || (eraseRun && eraseKind != EK_CHIP);
  wire goSusp = csRise && isSusp && lenOp && suspTarget && susTmr == '0 && statCnt == '0 && guardTmr == '0;
  wire goResm = idleOk && isResm && lenOp && anySusp;
  wire progOk = progStart && !in_progress_flag && !program_suspended_flag && progSt == OS_IDLE;

  // ======================================================
  // completion events
  wire eraseFin = eraseRun && eraseCnt == CNT_W'(1) && !(goSusp && !progRun);
  wire progFin = progRun && progCnt == CNT_W'(1) && !goSusp;
  wire statFin = statCnt == CNT_W'(1);

  // region base with low bits dropped and its run length
  wire [23:0] addrIn = shiftReg[23:0];
  wire [23:0] baseIn = isSect ? (addrIn & SECT_MASK) : isBlk32 ? (addrIn & BLK32_MASK) :
                       isBlk64 ? (addrIn & BLK64_MASK) : 24'h000000;
  wire sfe_erase_kind_t kindIn = isSect ? EK_SECT : isBlk32 ? EK_BLK32 : isBlk64 ? EK_BLK64 : EK_CHIP;
  wire [CNT_W-1:0] lenIn = isSect ? CNT_W'(SECT_ERASE_CYC) : isBlk32 ? CNT_W'(BLK32_ERASE_CYC) :
                           isBlk64 ? CNT_W'(BLK64_ERASE_CYC) : CNT_W'(CHIP_ERASE_CYC);

  // ======================================================
  // erase and program state machines
  always_comb
  begin
    next_eraseSt = eraseSt;
    unique case (eraseSt)
      OS_IDLE:
        if (goErase)
          next_eraseSt = OS_RUN;
      OS_RUN:
        if (goSusp && !progRun)
          next_eraseSt = OS_SUSP;
        else if (eraseFin)
          next_eraseSt = OS_IDLE;
      OS_SUSP:
        if (goResm && !program_suspended_flag)
          next_eraseSt = OS_RUN;
      default:
        next_eraseSt = OS_IDLE;
    endcase
  end

  always_comb
  begin
    next_progSt = progSt;
    unique case (progSt)
      OS_IDLE:
        if (progOk)
          next_progSt = OS_RUN;
      OS_RUN:
        if (goSusp)
          next_progSt = OS_SUSP;
        else if (progFin)
          next_progSt = OS_IDLE;
      OS_SUSP:
        if (goResm)
          next_progSt = OS_RUN;
      default:
        next_progSt = OS_IDLE;
    endcase
  end

  // write latch: set by command, cleared by clear command, suspend, function write or completion
  wire welClr = goClrWel || goSusp || eraseFin || progFin || statFin || goFuncWr;
  wire next_wel = goSetWel ? 1'b1 : welClr ? 1'b0 : writeEnableLatch;

  // ======================================================
  // shifter and control registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shiftReg <= 32'h00000000;
      bitCnt <= 6'h00;
      opcode <= 8'h00;
      rdStat <= 1'b0;
      rdFunc <= 1'b0;
    end
    else if (!csLow)
    begin
      bitCnt <= 6'h00;
      rdStat <= 1'b0;
      rdFunc <= 1'b0;
    end
    else if (sckRise)
    begin
      shiftReg <= shiftIn;
      bitCnt <= cntIn;
      if (opDone)
      begin
        opcode <= shiftIn[7:0];
        rdStat <= shiftIn[7:0] == OP_STAT_RD;
        rdFunc <= shiftIn[7:0] == OP_FUNC_RD && !in_progress_flag;
      end
    end
  end

  // operation counters and region capture
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      eraseSt <= OS_IDLE;
      progSt <= OS_IDLE;
      eraseKind <= EK_SECT;
      eraseBase <= 24'h000000;
      eraseCnt <= '0;
      progCnt <= '0;
    end
    else
    begin
      eraseSt <= next_eraseSt;
      progSt <= next_progSt;
      if (goErase)
      begin
        eraseKind <= kindIn;
        eraseBase <= baseIn;
        eraseCnt <= lenIn;
      end
      else if (eraseRun && next_eraseSt == OS_RUN)
        eraseCnt <= eraseCnt - CNT_W'(1); // held while suspended
      if (progOk)
        progCnt <= CNT_W'(PROG_CYC);
      else if (progRun && next_progSt == OS_RUN)
        progCnt <= progCnt - CNT_W'(1);
    end
  end

  // timers for status write, suspend latency and resume guard
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      statCnt <= '0;
      susTmr <= '0;
      guardTmr <= '0;
    end
    else
    begin
      statCnt <= goStatWr ? CNT_W'(STAT_WR_CYC) : (statCnt != '0) ? statCnt - CNT_W'(1) : statCnt;
      susTmr <= goSusp ? TMR_W'(SUS_READY_CYC) : (susTmr != '0) ? susTmr - TMR_W'(1) : susTmr;
      guardTmr <= goResm ? TMR_W'(RES_GUARD_CYC) : (guardTmr != '0) ? guardTmr - TMR_W'(1) : guardTmr;
    end
  end

  // latch, mode and stored settings
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      writeEnableLatch <= 1'b0;
      quadMode <= 1'b0;
      statNv <= STAT_NV_RESET;
      funcOtp <= FUNC_OTP_RESET;
      readParam <= RDPAR_RESET;
      extReadParam <= RDPAR_RESET;
    end
    else
    begin
      writeEnableLatch <= next_wel;
      if (goQuadOn || goQuadOff)
        quadMode <= goQuadOn;
      if (goStatWr)
        statNv <= shiftReg[7:0] & STAT_NV_MASK;
      if (goFuncWr)
        funcOtp <= funcOtp | (shiftReg[7:0] & FUNC_OTP_MASK);
      if (goRdPar)
        readParam <= shiftReg[7:0];
      if (goXRdPar)
        extReadParam <= shiftReg[7:0];
    end
  end

  // ======================================================
  // live register views
  logic [7:0] liveStat;
  logic [7:0] liveFunc;

  always_comb
  begin
    liveStat = statNv & STAT_NV_MASK;
    liveStat[ST_WEL] = writeEnableLatch;
    liveStat[ST_WIP] = in_progress_flag;
    liveFunc = funcOtp & FUNC_OTP_MASK;
    liveFunc[FR_PROGRAM_SUSPENDED_FLAG] = program_suspended_flag;
    liveFunc[FR_ERASE_SUSPENDED_FLAG] = erase_suspended_flag;
  end

  // ======================================================
  // read serialiser, shifts out on falling clock, repeats byte
  logic [7:0] curByte;
  logic [2:0] outPtr;

  wire [7:0] srcByte = (outPtr != 3'h0) ? curByte : rdStat ? liveStat : liveFunc;
  wire rdActive = rdStat | rdFunc;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      curByte <= 8'h00;
      outPtr <= 3'h0;
      ioOut <= 4'h0;
      ioOe <= 4'h0;
    end
    else if (!csLow || !rdActive)
    begin
      outPtr <= 3'h0;
      ioOut <= 4'h0;
      ioOe <= 4'h0;
    end
    else if (sckFall)
    begin
      ioOut <= quadMode ? srcByte[7:4] : {2'b00, srcByte[7], 1'b0};
      ioOe <= quadMode ? 4'hf : 4'h2;
      curByte <= quadMode ? {srcByte[3:0], 4'h0} : {srcByte[6:0], 1'b0};
      outPtr <= outPtr + (quadMode ? 3'h4 : 3'h1);
    end
  end

  // ======================================================
  // registered outputs
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      statusReg <= 8'h00;
      funcReg <= 8'h00;
      progDone <= 1'b0;
      eraseDone <= '0;
    end
    else
    begin
      statusReg <= liveStat;
      funcReg <= liveFunc;
      progDone <= progFin;
      eraseDone.valid <= eraseFin;
      eraseDone.kind <= eraseKind;
      eraseDone.base <= eraseBase;
    end
  end

endmodule

//--- logic/sfe_pkg.sv
package sfe_pkg;
  // ======================================================
  // opcodes
  localparam logic [7:0] OP_SECT_A = 8'hd7;
  localparam logic [7:0] OP_SECT_B = 8'h20;
  localparam logic [7:0] OP_BLK32 = 8'h52;
  localparam logic [7:0] OP_BLK64 = 8'hd8;
  localparam logic [7:0] OP_CHIP_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_B = 8'h60;
  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_FUNC_RD = 8'h48;
  localparam logic [7:0] OP_FUNC_WR = 8'h42;
  localparam logic [7:0] OP_QUAD_ON = 8'h35;
  localparam logic [7:0] OP_QUAD_OFF = 8'hf5;
  localparam logic [7:0] OP_SUSP_A = 8'h75;
  localparam logic [7:0] OP_SUSP_B = 8'hb0;
  localparam logic [7:0] OP_RESM_A = 8'h7a;
  localparam logic [7:0] OP_RESM_B = 8'h30;
  localparam logic [7:0] OP_RDPAR_A = 8'hc0;
  localparam logic [7:0] OP_RDPAR_B = 8'h63;
  localparam logic [7:0] OP_XRDPAR = 8'h83;
  // ======================================================
  // command lengths in bits
  localparam logic [5:0] LEN_OP = 6'h08;
  localparam logic [5:0] LEN_DATA = 6'h10;
  localparam logic [5:0] LEN_ADDR = 6'h20;
  localparam logic [5:0] LEN_SAT = 6'h38;
  // ======================================================
  // status and function register layout
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int FR_PROGRAM_SUSPENDED_FLAG = 2;
  localparam int FR_ERASE_SUSPENDED_FLAG = 3;
  localparam logic [7:0] STAT_NV_MASK = 8'hfc;
  localparam logic [7:0] FUNC_OTP_MASK = 8'hf3;
  localparam logic [7:0] STAT_NV_RESET = 8'h00;
  localparam logic [7:0] FUNC_OTP_RESET = 8'h00;
  localparam logic [7:0] RDPAR_RESET = 8'h00;
  // ======================================================
  // region alignment
  localparam logic [23:0] SECT_MASK = 24'hfff000;
  localparam logic [23:0] BLK32_MASK = 24'hff8000;
  localparam logic [23:0] BLK64_MASK = 24'hff0000;
  // ======================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SUS_READY_US = 100;
  localparam int RES_GUARD_US = 400;
  localparam int SUS_READY_CYC = SUS_READY_US * 1000 / CLK_PERIOD_NS;
  localparam int RES_GUARD_CYC = (RES_GUARD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 12;
  // ======================================================
  // types
  typedef enum logic [1:0] {EK_SECT, EK_BLK32, EK_BLK64, EK_CHIP} sfe_erase_kind_t;
  typedef enum logic [1:0] {OS_IDLE, OS_RUN, OS_SUSP} sfe_op_state_t;
  typedef struct packed {
    logic valid;
    sfe_erase_kind_t kind;
    logic [23:0] base;
  } sfe_erase_req_t;
endpackage

//--- tb/sfe_props.sv
`timescale 1ns/1ps
// ==========================================
// port checker
module sfe_props
  import sfe_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // pin and state
  input wire logic csN,
  input wire sfe_erase_req_t eraseDone,
  input wire logic [7:0] statusReg,
  input wire logic [7:0] funcReg,
  input wire logic quadMode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_done_clears_wel:
    assert property (eraseDone.valid |-> ##[1:3] (statusReg[ST_WEL] == 1'b0 && statusReg[ST_WIP] == 1'b0))
    else $error("latch or busy left after erase");
  a_region_align:
    assert property (eraseDone.valid |-> (eraseDone.base & ~(eraseDone.kind == EK_SECT ? SECT_MASK :
      eraseDone.kind == EK_BLK32 ? BLK32_MASK : eraseDone.kind == EK_BLK64 ? BLK64_MASK : 24'h000000)) == 24'h0)
    else $error("erase base not aligned");
  a_done_pulse:
    assert property (eraseDone.valid |=> !eraseDone.valid)
    else $error("erase request longer than one cycle");
  a_otp_sticky:
    assert property (($past(funcReg) & FUNC_OTP_MASK & ~funcReg) == 8'h00)
    else $error("one-time bit cleared");
  a_busy_on_release:
    assert property ($rose(statusReg[ST_WIP]) |-> csN)
    else $error("busy began with select low");
  a_mode_on_release:
    assert property ($changed(quadMode) |-> csN)
    else $error("mode changed inside frame");
  a_susp_drops_wel:
    assert property ($rose(funcReg[FR_ERASE_SUSPENDED_FLAG]) || $rose(funcReg[FR_PROGRAM_SUSPENDED_FLAG]) |-> ##[0:2]
      (statusReg[ST_WEL] == 1'b0 && statusReg[ST_WIP] == 1'b1))
    else $error("suspend kept latch or not busy");
  // cycles spent busy since a suspend flag rose, zero once busy drops
  logic [10:0] susAge;
  logic [1:0] susPrev;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      susAge <= 11'h000;
      susPrev <= 2'h0;
    end
    else
    begin
      susPrev <= {funcReg[FR_ERASE_SUSPENDED_FLAG], funcReg[FR_PROGRAM_SUSPENDED_FLAG]};
      if ((funcReg[FR_ERASE_SUSPENDED_FLAG] & ~susPrev[1]) | (funcReg[FR_PROGRAM_SUSPENDED_FLAG] & ~susPrev[0]))
        susAge <= 11'h001;
      else if (susAge != 11'h000 && statusReg[ST_WIP])
        susAge <= susAge + 11'h001;
      else
        susAge <= 11'h000;
    end
  end
  a_susp_ready:
    assert property (susAge <= 11'h3eb)
    else $error("suspend not ready in time");
  a_resume_release:
    assert property ($fell(funcReg[FR_ERASE_SUSPENDED_FLAG]) || $fell(funcReg[FR_PROGRAM_SUSPENDED_FLAG]) |-> csN)
    else $error("suspend flag cleared inside frame");
endmodule
bind sfe_erase_ctrl sfe_props chk_u (.clk_sys(clk_sys), .arst_n(arst_n), .csN(csN), .eraseDone(eraseDone),
  .statusReg(statusReg), .funcReg(funcReg), .quadMode(quadMode));

//--- tb/sfe_host.sv
`timescale 1ns/1ps
// ==========================================
// serial host model
module sfe_host (
  // clock
  input wire logic clk_sys,
  // driven pins
  output logic csN,
  output logic sck,
  output logic [3:0] hostIo,
  // device data
  input wire logic [3:0] ioOut
);
  // idle pins, clock stands low between frames
  initial
  begin
    csN = 1'b1;
    sck = 1'b0;
    hostIo = 4'h5;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // one frame of n bits msb first, then rd bits read back
  task automatic xfer(input logic [31:0] d, input int n, input logic q, input int rd, output logic [7:0] got);
    int step;
    step = q ? 4 : 1;
    got = 8'h00;
    csN = 1'b0;
    for (int i = n - step; i >= 0; i -= step)
    begin
      hostIo = q ? d[i +: 4] : {~hostIo[3:1], d[i]};
      tick(4);
      sck = 1'b1;
      tick(4);
      sck = 1'b0;
    end
    for (int j = 0; j < rd; j += step)
    begin
      hostIo = ~hostIo;
      tick(4);
      got = q ? {got[3:0], ioOut} : {got[6:0], ioOut[1]};
      sck = 1'b1;
      tick(4);
      sck = 1'b0;
    end
    tick(4);
    csN = 1'b1;
    hostIo = ~hostIo;
    tick(8);
  endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
// ==========================================
// testbench top
module tb;
  import sfe_pkg::*;
  logic clk_sys;
  logic arst_n;
  logic progStart;
  logic csN;
  logic sck;
  logic [3:0] hostIo;
  logic progDone;
  logic quadMode;
  logic q;
  logic [3:0] ioOut;
  logic [3:0] ioOe;
  logic [7:0] statusReg;
  logic [7:0] funcReg;
  logic [7:0] readParam;
  logic [7:0] extReadParam;
  logic [7:0] got;
  sfe_erase_req_t eraseDone;
  sfe_erase_req_t lastDone;
  wire [3:0] ioIn;
  int failures = 0;
  int n_tests = 0;
  int nDone = 0;
  int nProg = 0;
  logic [3:0] oeSeen = 4'h0;
  // wire level from both parties
  assign ioIn = (ioOe & ioOut) | (~ioOe & hostIo);
  sfe_erase_ctrl #(.SECT_ERASE_CYC(800), .BLK32_ERASE_CYC(900), .BLK64_ERASE_CYC(1000), .CHIP_ERASE_CYC(1100),
    .PROG_CYC(300)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .csN(csN), .sck(sck),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .progStart(progStart), .progDone(progDone), .eraseDone(eraseDone),
    .statusReg(statusReg), .funcReg(funcReg), .readParam(readParam), .extReadParam(extReadParam),
    .quadMode(quadMode));
  sfe_host host_u (.clk_sys(clk_sys), .csN(csN), .sck(sck), .hostIo(hostIo), .ioOut(ioOut));
  // clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // completion monitors
  always @(posedge clk_sys)
    if (eraseDone.valid === 1'b1)
    begin
      lastDone <= eraseDone;
      nDone <= nDone + 1;
    end
  always @(posedge clk_sys)
    if (progDone === 1'b1)
      nProg <= nProg + 1;
  // last non-idle output enable pattern
  always @(posedge clk_sys)
    if (ioOe !== 4'h0)
      oeSeen <= ioOe;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [31:0] d, input int n);
    host_u.xfer(d, n, q, 0, got);
  endtask
  task automatic wait_idle();
    int i;
    i = 0;
    while (statusReg[ST_WIP] !== 1'b0 && i < 6000)
    begin
      host_u.tick(1);
      i++;
    end
    chk(statusReg[ST_WIP], 1'b0);
  endtask
  task automatic t_erase();
    logic [7:0] ops [6] = '{OP_SECT_A, OP_SECT_B, OP_BLK32, OP_BLK64, OP_CHIP_A, OP_CHIP_B};
    sfe_erase_kind_t k [6] = '{EK_SECT, EK_SECT, EK_BLK32, EK_BLK64, EK_CHIP, EK_CHIP};
    logic [23:0] m [6] = '{SECT_MASK, SECT_MASK, BLK32_MASK, BLK64_MASK, 24'h000000, 24'h000000};
    logic [23:0] a;
    a = 24'h379abc;
    for (int i = 0; i < 6; i++)
    begin
      cmd(OP_SET_WEL, 8);
      if (k[i] == EK_CHIP)
        cmd(ops[i], 8);
      else
        cmd({ops[i], a}, 32);
      host_u.xfer(OP_STAT_RD, 8, q, 8, got);
      chk(got[1:0], 2'b11);
      chk(oeSeen, 4'h2);
      chk(ioOe, 4'h0);
      cmd(OP_CLR_WEL, 8);
      chk(statusReg[ST_WEL], 1'b1);
      wait_idle();
      chk(nDone, i + 1);
      chk(lastDone, {1'b1, k[i], a & m[i]});
      chk(statusReg[ST_WEL], 1'b0);
    end
    $display("erase kinds done");
  endtask
  task automatic t_refuse();
    chk(statusReg[ST_WEL], 1'b0);
    chk(quadMode, 1'b0);
    cmd(OP_SET_WEL, 8);
    cmd({OP_SECT_B, 16'h1000}, 24);
    chk(statusReg[ST_WIP], 1'b0);
    cmd(OP_CLR_WEL, 8);
    cmd({OP_SECT_B, 24'h001000}, 32);
    chk(statusReg[1:0], 2'b00);
    $display("refusals done");
  endtask
  task automatic t_susp();
    cmd(OP_SET_WEL, 8);
    cmd({OP_SECT_A, 24'h004321}, 32);
    cmd(OP_SUSP_B, 8);
    chk(funcReg[FR_ERASE_SUSPENDED_FLAG], 1'b1);
    chk(statusReg[ST_WEL], 1'b0);
    wait_idle();
    cmd(OP_SET_WEL, 8);
    chk(statusReg[ST_WEL], 1'b1);
    progStart = 1'b1;
    host_u.tick(1);
    progStart = 1'b0;
    host_u.tick(20);
    cmd(OP_SUSP_A, 8);
    chk(funcReg[3:2], 2'b11);
    wait_idle();
    cmd(OP_SET_WEL, 8);
    chk(statusReg[ST_WEL], 1'b0);
    cmd(OP_RESM_A, 8);
    chk(funcReg[3:2], 2'b10);
    wait_idle();
    chk(nProg, 1);
    cmd(OP_RESM_B, 8);
    chk(funcReg[3:2], 2'b00);
    wait_idle();
    chk(nDone, 7);
    $display("suspend and resume done");
  endtask
  task automatic t_quad();
    cmd(OP_QUAD_ON, 8);
    chk(quadMode, 1'b1);
    q = 1'b1;
    cmd(OP_SET_WEL, 8);
    host_u.xfer(OP_STAT_RD, 8, q, 8, got);
    chk(got, 8'h02);
    chk(oeSeen, 4'hf);
    chk(ioOe, 4'h0);
    cmd(OP_CLR_WEL, 8);
    cmd(OP_QUAD_OFF, 32);
    chk(quadMode, 1'b1);
    cmd(OP_QUAD_OFF, 8);
    chk(quadMode, 1'b0);
    q = 1'b0;
    $display("quad mode done");
  endtask
  task automatic t_regs();
    cmd({OP_RDPAR_A, 8'h5a}, 16);
    chk(readParam, 8'h5a);
    cmd({OP_RDPAR_B, 8'h3c}, 16);
    chk(readParam, 8'h3c);
    cmd({OP_XRDPAR, 8'ha5}, 16);
    chk(extReadParam, 8'ha5);
    cmd(OP_SET_WEL, 8);
    cmd({OP_STAT_WR, 8'hfc}, 16);
    wait_idle();
    chk(statusReg, 8'hfc);
    cmd(OP_SET_WEL, 8);
    cmd({OP_FUNC_WR, 8'hf3}, 16);
    cmd(OP_SET_WEL, 8);
    cmd({OP_FUNC_WR, 8'h00}, 16);
    chk(funcReg & FUNC_OTP_MASK, 8'hf3);
    $display("register writes done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial
  begin
    arst_n = 1'b0;
    progStart = 1'b0;
    q = 1'b0;
    host_u.tick(4);
    arst_n = 1'b1;
    host_u.tick(6);
    t_refuse();
    t_erase();
    t_susp();
    t_quad();
    t_regs();
    close_out();
  end
  // watchdog
  initial
  begin
    #6000000;
    failures++;
    close_out();
  end
endmodule
